// file: vsp_pkg.sv
package vsp_pkg;

  // Word and address layout of the serial command
  localparam int WORD_W       = 16;
  localparam int RW_BIT       = 15;
  localparam int ADDR_HI      = 14;
  localparam int ADDR_LO      = 8;
  localparam int DATA_HI      = 7;
  localparam int REG_BYTES    = 128;
  localparam logic [15:0] ESC_WORD = 16'hBEE8;

  // Burst frame layout, in word positions
  localparam int FRAME_WORDS  = 44;
  localparam int ZERO_WORDS   = 8;
  localparam int HDR_POS      = 8;
  localparam int SMP_FIRST    = 9;
  localparam int SMP_COUNT    = 32;
  localparam int SMP_LAST     = 40;
  localparam int TEMP_POS     = 41;
  localparam int STAT_POS     = 42;
  localparam int CRC_POS      = 43;
  localparam int FIRST_ZERO_SMP = 8;
  localparam logic [7:0]  HDR_LOW   = 8'hAD;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] SMP_EMPTY = 16'h8000;
  localparam int FIFO_DEPTH   = 16;

  // Whole state of the serial port, one register
  typedef struct packed {
    logic [1:0]                     sclk_s;
    logic [1:0]                     cs_s;
    logic [1:0]                     mosi_s;
    logic                           sclk_d;
    logic [3:0]                     bitcnt;
    logic [15:0]                    rx;
    logic [15:0]                    tx_sh;
    logic [15:0]                    tx_word;
    logic                           miso;
    logic                           ld;
    logic                           burst;
    logic [5:0]                     fidx;
    logic                           first_pend;
    logic                           frame_first;
    logic                           stream_d;
    logic [7:0]                     hdr_cnt;
    logic [15:0]                    crc;
    logic                           busy_n;
    logic                           esc;
    logic                           wr_stb;
    logic [6:0]                     wr_addr;
    logic [7:0]                     wr_data;
    logic                           done;
    logic [REG_BYTES-1:0][7:0]      mem;
  } vsp_state_s;

endpackage

// file: vsp_spi_port.sv
`timescale 1ns/1ns

// Sample buffer between the sampling logic and the burst reader
module vsp_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
  } vsp_fifo_s;
  vsp_fifo_s f_r, f_nxt;
  logic push, pop;

  // Ready is a flop so back-pressure reaches the source cleanly
  always_comb begin
    f_nxt = f_r;
    push = in_valid_in && f_r.rdy;
    pop  = out_ready_in && (f_r.cnt != '0);
    if (push) begin
      f_nxt.mem[f_r.wp] = in_data_in;
      f_nxt.wp = f_r.wp + 1'b1;
    end
    if (pop) begin
      f_nxt.rp = f_r.rp + 1'b1;
    end
    f_nxt.cnt = f_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    f_nxt.rdy = (f_nxt.cnt != (AW+1)'(D));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      f_r <= '0;
      f_r.rdy <= 1'b1;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign in_ready_out  = f_r.rdy;
  assign out_valid_out = (f_r.cnt != '0);
  assign out_data_out  = f_r.mem[f_r.rp];
endmodule

// Operation
// - Registers are 16 bits, low byte bits 7..0, high byte 15..8, each byte addressed.
// - Write command: flag one, 7-bit byte address, data byte; device stores the byte.
// - Read takes two words; register contents shift out during the second word.
// - Data bits of a read command are ignored.
// - Full duplex: a new read request is taken while previous data shifts out.
// - Busy output low while output data updates, high when data can be collected.
// - While busy, only the escape code is served; host waits for busy high. An open burst keeps sending its words while busy.
// - In streaming mode one command starts a burst of back-to-back words.
// - Chip select must stay low whole burst; early release discards the burst.
// - Burst is 44 words: 8 zeros, header, 32 samples, temperature, status, CRC.
// - Header has fixed low byte and a per-burst counter in the high byte.
// - Samples oldest first at byte offsets 18..80, then temperature, status, CRC.
// - First frame after entering streaming has eight zero samples and a bad CRC.
// - Link is clock polarity one, phase one, MSB first, 16-bit words, device slave.
module vsp_spi_port
  import vsp_pkg::*;
#(
  parameter int SMP_W = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              sys_clk_in,
  input  wire logic              reset_in,
  input  wire logic              sclk_in,
  input  wire logic              cs_n_in,
  input  wire logic              mosi_in,
  output logic                   miso_out,
  output logic                   busy_n_out,
  input  wire logic              proc_busy_in,
  input  wire logic              stream_mode_in,
  input  wire logic              acc_valid_in,
  input  wire logic [SMP_W-1:0]  acc_data_in,
  output logic                   acc_ready_out,
  input  wire logic [15:0]       temp_in,
  input  wire logic [15:0]       status_in,
  output logic                   escape_out,
  output logic                   wr_stb_out,
  output logic [6:0]             wr_addr_out,
  output logic [7:0]             wr_data_out,
  output logic                   burst_done_out
);
  vsp_state_s st_r, st_nxt;
  logic              smp_valid, smp_pop;
  logic [SMP_W-1:0]  smp_data;
  logic              rise, fall, cs_act, wdone;
  logic [15:0]       word;
  logic [15:0]       fw;
  logic [5:0]        nidx;
  logic [6:0]        addr;
  logic [15:0]       rd_val;

  vsp_fifo #(.W(SMP_W), .D(DEPTH)) u_fifo (
    .clk_in        (sys_clk_in),
    .rst_in        (reset_in),
    .in_valid_in   (acc_valid_in),
    .in_data_in    (acc_data_in),
    .in_ready_out  (acc_ready_out),
    .out_valid_out (smp_valid),
    .out_data_out  (smp_data),
    .out_ready_in  (smp_pop)
  );

  // CRC-16, MSB first, one word per call
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Edges of the synchronised link; only second stages are looked at
  assign rise   = st_r.sclk_s[1] && !st_r.sclk_d;
  assign fall   = !st_r.sclk_s[1] && st_r.sclk_d;
  assign cs_act = !st_r.cs_s[1];
  assign wdone  = cs_act && rise && (st_r.bitcnt == 4'hF);
  assign word   = {st_r.rx[14:0], st_r.mosi_s[1]};
  assign addr   = word[ADDR_HI:ADDR_LO];
  assign rd_val = {st_r.mem[{addr[6:1], 1'b1}], st_r.mem[{addr[6:1], 1'b0}]};
  assign nidx   = st_r.burst ? (st_r.fidx + 6'd1) : 6'd0;

  // Next frame word by position; samples drain the buffer oldest first
  always_comb begin
    fw = '0;
    smp_pop = 1'b0;
    if (wdone && (st_r.burst || (stream_mode_in && st_r.busy_n))) begin
      if (nidx < 6'(ZERO_WORDS)) begin
        fw = '0;
      end else if (nidx == 6'(HDR_POS)) begin
        fw = {st_r.hdr_cnt, HDR_LOW};
      end else if (nidx <= 6'(SMP_LAST)) begin
        smp_pop = smp_valid;
        if (st_r.frame_first && (nidx < 6'(SMP_FIRST + FIRST_ZERO_SMP))) begin
          fw = '0;
        end else begin
          fw = smp_valid ? 16'(smp_data) : SMP_EMPTY;
        end
      end else if (nidx == 6'(TEMP_POS)) begin
        fw = temp_in;
      end else if (nidx == 6'(STAT_POS)) begin
        fw = status_in;
      end else begin
        fw = st_r.frame_first ? ~st_r.crc : st_r.crc;
      end
    end
  end

  // Whole port state in one next-value process
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[0], sclk_in};
    st_nxt.cs_s   = {st_r.cs_s[0], cs_n_in};
    st_nxt.mosi_s = {st_r.mosi_s[0], mosi_in};
    st_nxt.sclk_d = st_r.sclk_s[1];
    st_nxt.busy_n = !proc_busy_in;
    st_nxt.stream_d = stream_mode_in;
    st_nxt.ld     = 1'b0;
    st_nxt.esc    = 1'b0;
    st_nxt.wr_stb = 1'b0;
    st_nxt.done   = 1'b0;
    if (stream_mode_in && !st_r.stream_d) begin
      st_nxt.first_pend = 1'b1;
    end
    if (!cs_act) begin
      st_nxt.bitcnt = '0;
      if (st_r.burst) begin
        st_nxt.burst   = 1'b0;
        st_nxt.tx_word = '0;
      end
    end else if (rise) begin
      // Sample on the rising edge, MSB first
      st_nxt.rx     = word;
      st_nxt.bitcnt = st_r.bitcnt + 4'd1;
    end else if (fall) begin
      // Drive on the falling edge; word boundary loads the next word
      if (st_r.bitcnt == 4'd0) begin
        st_nxt.miso  = st_r.tx_word[15];
        st_nxt.tx_sh = {st_r.tx_word[14:0], 1'b0};
      end else begin
        st_nxt.miso  = st_r.tx_sh[15];
        st_nxt.tx_sh = {st_r.tx_sh[14:0], 1'b0};
      end
    end
    if (wdone) begin
      st_nxt.ld = 1'b1;
      if (word == ESC_WORD) begin
        st_nxt.esc = 1'b1;
      end
      if (st_r.burst) begin
        // Words follow back to back, host input ignored but for the escape code
        st_nxt.tx_word = fw;
        st_nxt.fidx    = nidx;
        if (nidx < 6'(CRC_POS)) begin
          st_nxt.crc = crc16(st_r.crc, fw);
        end
        if (st_r.fidx == 6'(CRC_POS)) begin
          st_nxt.burst   = 1'b0;
          st_nxt.done    = 1'b1;
          st_nxt.hdr_cnt = st_r.hdr_cnt + 8'd1;
          st_nxt.tx_word = '0;
          st_nxt.fidx    = 6'd0;                        // Parked, never past the frame
        end
      end else if (!st_r.busy_n) begin
        st_nxt.tx_word = '0;
      end else if (stream_mode_in) begin
        // Any command word opens a burst
        st_nxt.burst       = 1'b1;
        st_nxt.fidx        = 6'd0;
        st_nxt.tx_word     = fw;
        st_nxt.crc         = crc16(CRC_INIT, fw);
        st_nxt.frame_first = st_r.first_pend || (stream_mode_in && !st_r.stream_d);
        st_nxt.first_pend  = 1'b0;
      end else if (word[RW_BIT]) begin
        st_nxt.mem[addr] = word[DATA_HI:0];
        st_nxt.wr_stb    = 1'b1;
        st_nxt.wr_addr   = addr;
        st_nxt.wr_data   = word[DATA_HI:0];
        st_nxt.tx_word   = '0;
      end else begin
        // Data bits dropped; contents return in the next word
        st_nxt.tx_word = rd_val;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st_r <= '0;
      st_r.sclk_s <= 2'b11;
      st_r.cs_s <= 2'b11;
      st_r.sclk_d <= 1'b1;
      st_r.first_pend <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // All outputs but acc_ready_out straight from the state register
  assign miso_out       = st_r.miso;
  assign busy_n_out     = st_r.busy_n;
  assign escape_out     = st_r.esc;
  assign wr_stb_out     = st_r.wr_stb;
  assign wr_addr_out    = st_r.wr_addr;
  assign wr_data_out    = st_r.wr_data;
  assign burst_done_out = st_r.done;

  // Checks on the port behaviour
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  property p_busy_follow;
    proc_busy_in |=> !busy_n_out ##1 (busy_n_out == !$past(proc_busy_in));
  endproperty
  a_busy_follow: assert property (p_busy_follow) else $error("busy not following");

  property p_write_store;
    wr_stb_out |-> (st_r.mem[wr_addr_out] == wr_data_out);
  endproperty
  a_write_store: assert property (p_write_store) else $error("byte not stored");

  property p_busy_block;
    (wdone && !busy_n_out) |=> !wr_stb_out && (st_r.tx_word == 16'h0000) && !st_r.burst;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("access served while busy");

  property p_read_pipe;
    (wdone && busy_n_out && !st_r.burst && !stream_mode_in && !word[RW_BIT])
      |=> !wr_stb_out && (st_r.tx_word == $past(rd_val));
  endproperty
  a_read_pipe: assert property (p_read_pipe) else $error("read data wrong");

  property p_frame_len;
    st_r.fidx <= 6'(CRC_POS);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame too long");

  property p_abort;
    (st_r.burst && !cs_act) |=> !st_r.burst && !burst_done_out;
  endproperty
  a_abort: assert property (p_abort) else $error("burst kept after release");

  property p_header;
    (st_r.ld && st_r.burst && st_r.fidx == 6'(HDR_POS))
      |-> st_r.tx_word == {st_r.hdr_cnt, HDR_LOW};
  endproperty
  a_header: assert property (p_header) else $error("header word wrong");

  property p_first_zero;
    (st_r.ld && st_r.burst && st_r.frame_first && st_r.fidx >= 6'(SMP_FIRST)
      && st_r.fidx < 6'(SMP_FIRST + FIRST_ZERO_SMP)) |-> st_r.tx_word == 16'h0000;
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("first samples not zero");

  property p_msb_first;
    (cs_act && fall && st_r.bitcnt == 4'd0) |=> miso_out == $past(st_r.tx_word[15]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

  property p_done_count;
    burst_done_out |-> st_r.hdr_cnt == $past(st_r.hdr_cnt) + 8'd1;
  endproperty
  a_done_count: assert property (p_done_count) else $error("counter not stepped");

  property p_escape_seen;
    (wdone && word == ESC_WORD) |=> escape_out;
  endproperty
  a_escape_seen: assert property (p_escape_seen) else $error("escape not flagged");

  property p_stream_start;
    (wdone && !st_r.burst && stream_mode_in && busy_n_out)
      |=> st_r.burst && st_r.fidx == 6'd0 && st_r.tx_word == 16'h0000;
  endproperty
  a_stream_start: assert property (p_stream_start) else $error("burst not opened");

  property p_done_end;
    burst_done_out |-> !st_r.burst && $past(st_r.fidx) == 6'(CRC_POS);
  endproperty
  a_done_end: assert property (p_done_end) else $error("burst ended early");

  c_write:  cover property (wr_stb_out);
  c_read:   cover property (st_r.ld && !st_r.burst && st_r.tx_word != 16'h0000);
  c_burst:  cover property (burst_done_out);
  c_escape: cover property (escape_out && !busy_n_out);
  c_abort:  cover property (st_r.burst && !cs_act);
endmodule

// file: vsp_host_model.sv
`timescale 1ns/1ns

// Serial master on the far side; drives on falling system edges
module vsp_host_model (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // Idle: clock high, deselected
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Frame select; a released data line shows the inverse of its last bit
  task automatic select(input logic on);
    @(negedge clk_in);
    cs_n_out = ~on;
    if (!on) mosi_out = ~mosi_out;
    repeat (4) @(negedge clk_in);
  endtask

  // One word, MSB first, shift on fall, sample on rise
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    for (int b = 15; b >= 0; b--) begin
      @(negedge clk_in);
      sclk_out = 1'b0;
      mosi_out = tx[b];
      // Half period of four system cycles, well below the streaming range:
      // the port finds link edges with its own clock, so faster is unsafe
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      rx[b]    = miso_in;
      repeat (3) @(negedge clk_in);
    end
  endtask
endmodule

// file: vsp_spi_port_bench.sv
`timescale 1ns/1ns

module vsp_spi_port_bench;
  import vsp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, cs_n, mosi, miso, busy_n, escape, wr_stb, done;
  logic        proc_busy;
  logic        stream;
  logic        acc_valid;
  logic        acc_ready;
  logic [15:0] acc_data;
  logic [15:0] temp;
  logic [15:0] status;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [15:0] rx;
  int          mismatches = 0;
  int          tests_run = 0;
  int          n_esc = 0;
  int          n_wr = 0;
  int          n_done = 0;

  // 25 MHz system clock
  always #20 clk = ~clk;

  vsp_spi_port vsp_spi_port_i (
    .sys_clk_in(clk), .reset_in(rst), .sclk_in(sclk), .cs_n_in(cs_n),
    .mosi_in(mosi), .miso_out(miso), .busy_n_out(busy_n),
    .proc_busy_in(proc_busy), .stream_mode_in(stream),
    .acc_valid_in(acc_valid), .acc_data_in(acc_data), .acc_ready_out(acc_ready),
    .temp_in(temp), .status_in(status), .escape_out(escape),
    .wr_stb_out(wr_stb), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .burst_done_out(done)
  );

  vsp_host_model vsp_host_model_i (
    .clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso)
  );

  // Pulse counters; strobes last one cycle so each edge is looked at
  always @(posedge clk) begin
    if (escape === 1'b1) n_esc++;
    if (wr_stb === 1'b1) n_wr++;
    if (done === 1'b1) n_done++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One command word in its own frame
  task automatic frame1(input logic [15:0] tx);
    vsp_host_model_i.select(1'b1);
    vsp_host_model_i.xfer(tx, rx);
    vsp_host_model_i.select(1'b0);
  endtask

  task automatic t_regs;
    frame1(16'h8623);
    check({9'h000, wr_addr}, 16'h0006);
    check({8'h00, wr_data}, 16'h0023);
    frame1(16'h8745);
    frame1(16'h8C5A);
    check(16'(n_wr), 16'h0003);
    vsp_host_model_i.select(1'b1);
    vsp_host_model_i.xfer(16'h06A5, rx);
    vsp_host_model_i.xfer(16'h0C00, rx);
    check(rx, 16'h4523);
    vsp_host_model_i.xfer(16'h0000, rx);
    check({8'h00, rx[7:0]}, 16'h005A);
    vsp_host_model_i.select(1'b0);
    $display("test regs done");
  endtask

  task automatic t_busy;
    @(negedge clk) proc_busy = 1'b1;
    repeat (2) @(negedge clk);
    check({15'h0000, busy_n}, 16'h0000);
    frame1(16'h8C77);
    frame1(ESC_WORD);
    check(16'(n_esc), 16'h0001);
    @(negedge clk) proc_busy = 1'b0;
    repeat (2) @(negedge clk);
    check({15'h0000, busy_n}, 16'h0001);
    vsp_host_model_i.select(1'b1);
    vsp_host_model_i.xfer(16'h0C00, rx);
    vsp_host_model_i.xfer(16'h0000, rx);
    vsp_host_model_i.select(1'b0);
    check({8'h00, rx[7:0]}, 16'h005A);
    $display("test busy done");
  endtask

  // Whole burst, CS held low to the last word; expectations built here
  task automatic run_burst(input logic first, input logic [7:0] cnt, input int nf);
    logic [15:0] e, crc;
    int d, k;
    crc = 16'hFFFF;
    d = n_done;
    vsp_host_model_i.select(1'b1);
    vsp_host_model_i.xfer(16'h0000, rx);
    for (int i = 0; i < CRC_POS; i++) begin
      k = i - SMP_FIRST;
      if (i < ZERO_WORDS) e = 16'h0000;
      else if (i == HDR_POS) e = {cnt, HDR_LOW};
      else if (i == TEMP_POS) e = temp;
      else if (i == STAT_POS) e = status;
      else if (first && k < 8) e = 16'h0000;
      else if (k < nf) e = 16'hA000 + 16'(k);
      else e = SMP_EMPTY;
      vsp_host_model_i.xfer(16'h0000, rx);
      check(rx, e);
      if (e == SMP_EMPTY) check(rx - SMP_EMPTY, 16'h0000);
      for (int b = 15; b >= 0; b--) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ e[b]) ? CRC_POLY : 0);
    end
    vsp_host_model_i.xfer(16'h0000, rx);
    vsp_host_model_i.select(1'b0);
    check(rx, first ? ~crc : crc);
    check(16'(n_done - d), 16'h0001);
  endtask

  task automatic t_first;
    @(negedge clk) stream = 1'b1;
    repeat (2) @(negedge clk);
    run_burst(1'b1, 8'h00, 0);
    $display("test first frame done");
  endtask

  task automatic t_fill;
    int n;
    n = 0;
    for (int j = 0; j < 20 && n == j; j++) begin
      @(negedge clk);
      acc_valid = 1'b1;
      acc_data = 16'hA000 + 16'(n);
      if (acc_ready === 1'b1) n++;
    end
    @(negedge clk) acc_valid = 1'b0;
    check(16'(n), 16'(FIFO_DEPTH));
    temp = 16'h1357;
    run_burst(1'b0, 8'h01, n);
    $display("test fill done");
  endtask

  task automatic t_abort;
    int d;
    d = n_done;
    status = 16'h0042;
    vsp_host_model_i.select(1'b1);
    for (int i = 0; i < 11; i++) vsp_host_model_i.xfer(16'h0000, rx);
    vsp_host_model_i.select(1'b0);
    check(16'(n_done - d), 16'h0000);
    run_burst(1'b0, 8'h02, 0);
    $display("test abort done");
  endtask

  // Re-enter streaming; a command while busy must not use up the first frame
  task automatic t_reenter;
    @(negedge clk) stream = 1'b0;
    @(negedge clk) proc_busy = 1'b1;
    stream = 1'b1;
    repeat (2) @(negedge clk);
    frame1(16'h0000);
    @(negedge clk) proc_busy = 1'b0;
    repeat (2) @(negedge clk);
    run_burst(1'b1, 8'h03, 0);
    $display("test reenter done");
  endtask

  // Reset, then the scenarios in order
  initial begin
    proc_busy = 1'b0;
    stream = 1'b0;
    acc_valid = 1'b0;
    acc_data = 16'h0000;
    temp = 16'h1234;
    status = 16'h00C3;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_regs;
    t_busy;
    t_first;
    t_fill;
    t_abort;
    t_reenter;
    close_out;
  end

  // Watchdog, about twice the expected run
  initial begin
    #2_000_000;
    mismatches++;
    close_out;
  end
endmodule
